/* verilog/idar_remapper.sv */
`timescale 1ns/1ps
`default_nettype none
`include "idar_consts.svh"
module idar_remapper (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire logic [15:0] reqBdf,
	input wire logic [`IDAR_AW-1:0] reqAddr,
	input wire logic reqWrite,
	input wire logic [3:0] reqByteEn,
	input wire logic reqExternal,
	output logic reqReady,
	output logic fwdValid,
	output logic [`IDAR_AW-1:0] fwdAddr,
	output logic fwdWrite,
	output logic [3:0] fwdByteEn,
	output logic fwdUnsupported,
	output logic fwdFault,
	input wire logic fwdReady,
	input wire logic fwdComplete,
	output logic memReqValid,
	output logic [`IDAR_AW-1:0] memReqAddr,
	input wire logic memRspValid,
	input wire logic [63:0] memRspData,
	input wire logic transEnable,
	input wire logic bootProtect,
	input wire logic intrRemapEnable,
	input wire logic defaultCtxEnable,
	input wire logic [15:0] gfxBdf,
	input wire logic [`IDAR_AW-1:0] rootPtrGfx,
	input wire logic [`IDAR_AW-1:0] rootPtrDef,
	input wire logic [`IDAR_AW-1:0] defaultCtxPtr,
	input wire logic [7:0] defaultDomain,
	input wire logic [`IDAR_AW-1:0] bypassBase,
	input wire logic [`IDAR_AW-1:0] bypassLimit,
	input wire logic [`IDAR_AW-1:0] videoBiosBase,
	input wire logic [`IDAR_AW-1:0] intrTableBase,
	input wire logic qiEnable,
	input wire logic [`IDAR_AW-1:0] qiBase,
	input wire logic [7:0] qiTail,
	output logic [7:0] qiHead,
	output logic invDone,
	output logic faultValid,
	output logic [15:0] faultBdf,
	output logic [`IDAR_AW-1:0] faultAddr,
	output logic faultOverflow,
	output logic faultMsi,
	input wire logic faultClear
);
	// ****************************************
	// state and captured request
	// ****************************************
	idar_pkg::idar_state_t state_reg, stateNext;
	logic [15:0] rqBdf_reg;
	logic [`IDAR_AW-1:0] rqAddr_reg;
	logic rqWr_reg, rqExt_reg, rqGfx_reg, reqReady_reg;
	logic [3:0] rqBe_reg;
	logic [7:0] ctxDom_reg, ctxDomNext;
	logic [26:0] ctxPtr_reg, ctxPtrNext;
	logic [1:0] lvl_reg;
	logic memReqValid_reg, fwdValid_reg, fwdWrite_reg, fwdUr_reg, fwdFault_reg;
	logic [`IDAR_AW-1:0] memReqAddr_reg, fwdAddr_reg, memAddrNext, fwdAddrNext;
	logic [3:0] fwdBe_reg;
	logic [7:0] outstanding_reg, qHead_reg;
	logic invDone_reg, faultValid_reg, faultOvf_reg, faultMsi_reg;
	logic [15:0] faultBdf_reg;
	logic [`IDAR_AW-1:0] faultAddr_reg;
	idar_pkg::idar_gran_t invGran_reg;
	logic [7:0] invDom_reg;
	logic [26:0] invKey_reg;
	logic memIssue, fwdLoad, faultEvt, ctxLoad, lvlAdv, ctxFill, leafFill;
	logic transUse, qLatch, invFire;

	// ****************************************
	// address decode and table addressing
	// ****************************************
	wire logic takeReq = reqValid && reqReady_reg;
	wire logic isMsi = rqAddr_reg[38:20] == `IDAR_MSI_HI;
	wire logic inBypass = rqAddr_reg >= bypassBase && rqAddr_reg <= bypassLimit;
	wire logic rspPresent = memRspData[`IDAR_PRESENT];
	wire logic rspPass = memRspData[`IDAR_PASSTHRU];
	wire logic [26:0] rspPtr = memRspData[38:12];
	wire logic [7:0] rspDom = memRspData[`IDAR_DOM_LO +: 8];
	// engine select: graphics requester or default engine
	wire logic [`IDAR_AW-1:0] rootBase = rqGfx_reg ? rootPtrGfx : rootPtrDef;
	wire logic [`IDAR_AW-1:0] rootAddr = rootBase + {28'h0, rqBdf_reg[15:8], 3'h0};
	wire logic [`IDAR_AW-1:0] ctxAddr = {rspPtr, 12'h000} + {28'h0, rqBdf_reg[7:0], 3'h0};
	wire logic inWalk = state_reg == idar_pkg::IDAR_WALK;
	wire logic [1:0] idxLvl = inWalk ? lvl_reg + 2'h1 : 2'h0;
	wire logic [8:0] lvlIdx = (idxLvl == 2'h0) ? rqAddr_reg[38:30]
		: (idxLvl == 2'h1) ? rqAddr_reg[29:21] : rqAddr_reg[20:12];
	wire logic [26:0] pteBase = inWalk ? rspPtr : ctxPtr_reg;
	wire logic [`IDAR_AW-1:0] pteAddr = {pteBase, 12'h000} + {27'h0, lvlIdx, 3'h0};
	wire logic [7:0] handle = rqAddr_reg[`IDAR_HANDLE_LO +: 8];
	wire logic [`IDAR_AW-1:0] irteAddr = intrTableBase + {28'h0, handle, 3'h0};
	wire logic [`IDAR_AW-1:0] qiAddr = qiBase + {28'h0, qHead_reg, 3'h0};
	wire logic isLeaf = lvl_reg == `IDAR_LAST_LVL || memRspData[`IDAR_SUPERPAGE];
	wire logic [26:0] lvlMask = (lvl_reg == 2'h0) ? `IDAR_MASK_1G
		: (lvl_reg == 2'h1) ? `IDAR_MASK_2M : `IDAR_MASK_4K;

	// ****************************************
	// translation caches, one per engine
	// ****************************************
	wire logic keyLeaf = state_reg == idar_pkg::IDAR_LEAF || inWalk;
	wire logic [27:0] tlbKey = keyLeaf ? {1'b1, rqAddr_reg[38:12]} : {12'h000, rqBdf_reg};
	wire logic [26:0] fillMask = leafFill ? lvlMask : `IDAR_MASK_4K;
	wire logic [35:0] fillData = leafFill ? {9'h000, rspPtr} : {rspPass, rspDom, rspPtr};
	logic tlbHit [2];
	logic [35:0] tlbData [2];
	logic [26:0] tlbMask [2];
	for (genvar e = 0; e < 2; e++) begin : g_engine
		idar_tlb u_tlb (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.clkEn(clkEn),
			.lookKey(tlbKey),
			.lookDom(ctxDom_reg),
			.lookHit(tlbHit[e]),
			.lookData(tlbData[e]),
			.lookMask(tlbMask[e]),
			.fillEn((ctxFill || leafFill) && rqGfx_reg == (e == 1)),
			.fillKey(tlbKey),
			.fillMask(fillMask),
			.fillDom(ctxFill ? rspDom : ctxDom_reg),
			.fillData(fillData),
			.invEn(invFire),
			.invGran(invGran_reg),
			.invDom(invDom_reg),
			.invKey(invKey_reg)
		);
	end
	wire logic selHit = rqGfx_reg ? tlbHit[1] : tlbHit[0];
	wire logic [35:0] selData = rqGfx_reg ? tlbData[1] : tlbData[0];
	// translated address, cached or freshly walked
	wire logic [26:0] transPpn = inWalk ? rspPtr : selData[26:0];
	wire logic [38:0] transMask = {inWalk ? lvlMask : (rqGfx_reg ? tlbMask[1] : tlbMask[0]), 12'h000};
	wire logic [`IDAR_AW-1:0] physAddr = ({transPpn, 12'h000} & transMask) | (rqAddr_reg & ~transMask);

	// ****************************************
	// sequencer
	// ****************************************
	// next state and per-state strobes
	always_comb begin
		stateNext = state_reg;
		memIssue = 1'b0;
		memAddrNext = rootAddr;
		fwdLoad = 1'b0;
		faultEvt = 1'b0;
		ctxLoad = 1'b0;
		ctxDomNext = defaultDomain;
		ctxPtrNext = defaultCtxPtr[38:12];
		lvlAdv = 1'b0;
		ctxFill = 1'b0;
		leafFill = 1'b0;
		transUse = 1'b0;
		qLatch = 1'b0;
		invFire = 1'b0;
		case (state_reg)
			idar_pkg::IDAR_IDLE: begin
				if (takeReq) begin
					stateNext = idar_pkg::IDAR_LOOK;
				end else if (qiEnable && qHead_reg != qiTail) begin
					stateNext = idar_pkg::IDAR_QREAD;
					memIssue = 1'b1;
					memAddrNext = qiAddr;
				end
			end
			idar_pkg::IDAR_LOOK: begin
				if (isMsi && rqWr_reg) begin
					if (intrRemapEnable) begin
						stateNext = idar_pkg::IDAR_INTR;
						memIssue = 1'b1;
						memAddrNext = irteAddr;
					end else fwdLoad = 1'b1;
				end else if (!transEnable) begin
					faultEvt = bootProtect;
					fwdLoad = !bootProtect;
				end else if (inBypass) begin
					fwdLoad = 1'b1;
				end else if (selHit) begin
					fwdLoad = selData[35];
					ctxLoad = !selData[35];
					ctxDomNext = selData[34:27];
					ctxPtrNext = selData[26:0];
				end else begin
					stateNext = idar_pkg::IDAR_ROOT;
					memIssue = 1'b1;
				end
			end
			idar_pkg::IDAR_ROOT, idar_pkg::IDAR_CTX: begin
				if (memRspValid) begin
					if (rspPresent && state_reg == idar_pkg::IDAR_ROOT) begin
						stateNext = idar_pkg::IDAR_CTX;
						memIssue = 1'b1;
						memAddrNext = ctxAddr;
					end else if (rspPresent) begin
						ctxFill = 1'b1;
						fwdLoad = rspPass;
						ctxLoad = !rspPass;
						ctxDomNext = rspDom;
						ctxPtrNext = rspPtr;
					end else if (defaultCtxEnable) begin
						ctxLoad = 1'b1;
					end else faultEvt = 1'b1;
				end
			end
			idar_pkg::IDAR_LEAF: begin
				if (selHit) begin
					fwdLoad = 1'b1;
					transUse = 1'b1;
				end else begin
					stateNext = idar_pkg::IDAR_WALK;
					memIssue = 1'b1;
					memAddrNext = pteAddr;
				end
			end
			idar_pkg::IDAR_WALK: begin
				if (memRspValid) begin
					if (!rspPresent) faultEvt = 1'b1;
					else if (isLeaf) begin
						leafFill = 1'b1;
						fwdLoad = 1'b1;
						transUse = 1'b1;
					end else begin
						lvlAdv = 1'b1;
						memIssue = 1'b1;
						memAddrNext = pteAddr;
					end
				end
			end
			idar_pkg::IDAR_INTR: begin
				if (memRspValid) begin
					fwdLoad = rspPresent;
					faultEvt = !rspPresent;
				end
			end
			idar_pkg::IDAR_FWD: begin
				if (fwdReady) stateNext = idar_pkg::IDAR_IDLE;
			end
			idar_pkg::IDAR_QREAD: begin
				if (memRspValid) begin
					qLatch = 1'b1;
					stateNext = idar_pkg::IDAR_DRAIN;
				end
			end
			idar_pkg::IDAR_DRAIN: begin
				if (outstanding_reg == 8'h00) begin
					invFire = 1'b1;
					stateNext = idar_pkg::IDAR_IDLE;
				end
			end
			default: stateNext = idar_pkg::IDAR_IDLE;
		endcase
		if (ctxLoad) stateNext = idar_pkg::IDAR_LEAF;
		if (fwdLoad || faultEvt) stateNext = idar_pkg::IDAR_FWD;
	end

	// forwarded address: translated, remapped interrupt, fault target or as received
	always_comb begin
		fwdAddrNext = rqAddr_reg;
		if (transUse) fwdAddrNext = physAddr;
		if (state_reg == idar_pkg::IDAR_INTR) begin
			fwdAddrNext = {`IDAR_MSI_HI, memRspData[`IDAR_IRT_DEST_LO +: 8], 12'h000};
		end
		if (faultEvt) fwdAddrNext = videoBiosBase;
	end

	// state, request capture and walk context
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= idar_pkg::IDAR_IDLE;
			reqReady_reg <= 1'b0;
			{rqBdf_reg, rqAddr_reg, rqWr_reg, rqBe_reg, rqExt_reg, rqGfx_reg} <= '0;
			{ctxDom_reg, ctxPtr_reg, lvl_reg} <= '0;
		end else if (clkEn) begin
			state_reg <= stateNext;
			reqReady_reg <= stateNext == idar_pkg::IDAR_IDLE;
			if (takeReq) begin
				{rqBdf_reg, rqAddr_reg, rqWr_reg} <= {reqBdf, reqAddr, reqWrite};
				{rqBe_reg, rqExt_reg, rqGfx_reg} <= {reqByteEn, reqExternal, reqBdf == gfxBdf};
			end
			if (ctxLoad) {ctxDom_reg, ctxPtr_reg, lvl_reg} <= {ctxDomNext, ctxPtrNext, 2'h0};
			if (lvlAdv) lvl_reg <= lvl_reg + 2'h1;
		end
	end

	// memory read port and forward port
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{memReqValid_reg, memReqAddr_reg} <= '0;
			{fwdValid_reg, fwdAddr_reg, fwdWrite_reg, fwdBe_reg, fwdUr_reg, fwdFault_reg} <= '0;
		end else if (clkEn) begin
			memReqValid_reg <= memIssue;
			if (memIssue) memReqAddr_reg <= memAddrNext;
			if (fwdLoad || faultEvt) begin
				{fwdValid_reg, fwdAddr_reg, fwdWrite_reg} <= {1'b1, fwdAddrNext, rqWr_reg};
				fwdBe_reg <= (faultEvt && rqWr_reg) ? 4'h0 : rqBe_reg;
				fwdUr_reg <= faultEvt && !rqWr_reg && rqExt_reg;
				fwdFault_reg <= faultEvt;
			end else if (fwdReady) fwdValid_reg <= 1'b0;
		end
	end

	// outstanding accesses, invalidation queue, fault record
	wire logic fwdTaken = fwdValid_reg && fwdReady;
	wire logic recordNew = faultEvt && (!faultValid_reg || faultClear);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{outstanding_reg, qHead_reg, invDone_reg} <= '0;
			{invGran_reg, invDom_reg, invKey_reg} <= '0;
			{faultValid_reg, faultOvf_reg, faultMsi_reg, faultBdf_reg, faultAddr_reg} <= '0;
		end else if (clkEn) begin
			outstanding_reg <= outstanding_reg + {7'h00, fwdTaken} - {7'h00, fwdComplete};
			if (qLatch) begin
				invGran_reg <= idar_pkg::idar_gran_t'(memRspData[1:0]);
				{invDom_reg, invKey_reg} <= {memRspData[15:8], memRspData[38:12]};
			end
			invDone_reg <= invFire;
			if (invFire) qHead_reg <= qHead_reg + 8'h01;
			// keep first fault, set wins over clear
			faultValid_reg <= faultEvt || (faultValid_reg && !faultClear);
			faultOvf_reg <= (faultEvt && faultValid_reg && !faultClear) || (faultOvf_reg && !faultClear);
			faultMsi_reg <= recordNew;
			if (recordNew) {faultBdf_reg, faultAddr_reg} <= {rqBdf_reg, rqAddr_reg};
		end
	end

	// outputs straight from flip-flops
	assign reqReady = reqReady_reg;
	assign {fwdValid, fwdAddr, fwdWrite, fwdByteEn} = {fwdValid_reg, fwdAddr_reg, fwdWrite_reg, fwdBe_reg};
	assign {fwdUnsupported, fwdFault} = {fwdUr_reg, fwdFault_reg};
	assign {memReqValid, memReqAddr} = {memReqValid_reg, memReqAddr_reg};
	assign {qiHead, invDone} = {qHead_reg, invDone_reg};
	assign {faultValid, faultBdf, faultAddr} = {faultValid_reg, faultBdf_reg, faultAddr_reg};
	assign {faultOverflow, faultMsi} = {faultOvf_reg, faultMsi_reg};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst || !clkEn);
	wire logic inLook = state_reg == idar_pkg::IDAR_LOOK;
	a_msi_bypass: assert property (
		inLook && isMsi && rqWr_reg && !intrRemapEnable
		|=> fwdValid && !fwdFault && fwdAddr == $past(rqAddr_reg))
		else $error("msi write was not passed through");
	a_boot_guard: assert property (
		inLook && !transEnable && bootProtect && !(isMsi && rqWr_reg) |=> fwdValid && fwdFault)
		else $error("boot protection did not fault");
	a_fault_target: assert property (
		fwdValid && fwdFault |-> fwdAddr == videoBiosBase && (!fwdWrite || fwdByteEn == 4'h0))
		else $error("fault not redirected to video bios region");
	a_ur_status: assert property (
		fwdValid && fwdFault |-> fwdUnsupported == (!fwdWrite && rqExt_reg))
		else $error("unsupported request status wrong");
	a_walk_fault: assert property (
		inWalk && memRspValid && !rspPresent |=> fwdFault ##1 !memReqValid)
		else $error("missing entry did not fault");
	a_root_index: assert property (
		inLook && transEnable && !inBypass && !selHit && !isMsi
		|=> memReqValid && memReqAddr == $past(rootAddr))
		else $error("root entry address not indexed by bus");
	a_fault_keep: assert property (
		faultValid && faultEvt && !faultClear |=> faultOverflow && faultAddr == $past(faultAddr))
		else $error("occupied fault record was overwritten");
	a_fault_msi: assert property (
		recordNew |=> faultMsi && faultValid && faultAddr == $past(rqAddr_reg) ##1 !faultMsi)
		else $error("fault message pulse missing");
	a_drain_first: assert property (
		state_reg == idar_pkg::IDAR_DRAIN && outstanding_reg != 8'h00 |=> !invDone)
		else $error("invalidation finished with accesses pending");
	a_no_bad_fill: assert property (
		inWalk && memRspValid && !rspPresent |-> !leafFill && !ctxFill)
		else $error("invalid entry placed in cache");
	c_fault_seen: cover property (fwdValid && fwdFault && fwdReady);
	c_inv_done: cover property (invDone);
	c_superpage: cover property (leafFill && lvl_reg != `IDAR_LAST_LVL);
	c_overflow: cover property ($rose(faultOverflow));
endmodule // idar_remapper
`default_nettype wire

/* verilog/idar_consts.svh */
`ifndef IDAR_CONSTS_SVH
`define IDAR_CONSTS_SVH
// address and table geometry
`define IDAR_AW 39
`define IDAR_PW 27
`define IDAR_ENTRIES 4
`define IDAR_LAST_LVL 2'h2
// message-signalled-interrupt window, address bits 38..20
`define IDAR_MSI_HI 19'h00fee
// table entry fields
`define IDAR_PRESENT 0
`define IDAR_PASSTHRU 3
`define IDAR_SUPERPAGE 7
`define IDAR_DOM_LO 56
`define IDAR_IRT_DEST_LO 8
`define IDAR_HANDLE_LO 5
// page masks on the page number, 4 KB, 2 MB, 1 GB
`define IDAR_MASK_4K 27'h7ffffff
`define IDAR_MASK_2M 27'h7fffe00
`define IDAR_MASK_1G 27'h7fc0000
`endif

/* verilog/idar_pkg.sv */
package idar_pkg;
	typedef enum logic [9:0] {
		IDAR_IDLE = 10'h001,
		IDAR_LOOK = 10'h002,
		IDAR_ROOT = 10'h004,
		IDAR_CTX = 10'h008,
		IDAR_LEAF = 10'h010,
		IDAR_WALK = 10'h020,
		IDAR_INTR = 10'h040,
		IDAR_FWD = 10'h080,
		IDAR_QREAD = 10'h100,
		IDAR_DRAIN = 10'h200
	} idar_state_t;
	typedef enum logic [1:0] {
		IDAR_INV_ALL = 2'h0,
		IDAR_INV_DOM = 2'h1,
		IDAR_INV_PAGE = 2'h2
	} idar_gran_t;
endpackage

/* verilog/idar_tlb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "idar_consts.svh"
module idar_tlb (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic [27:0] lookKey,
	input wire logic [7:0] lookDom,
	output logic lookHit,
	output logic [35:0] lookData,
	output logic [26:0] lookMask,
	input wire logic fillEn,
	input wire logic [27:0] fillKey,
	input wire logic [26:0] fillMask,
	input wire logic [7:0] fillDom,
	input wire logic [35:0] fillData,
	input wire logic invEn,
	input wire idar_pkg::idar_gran_t invGran,
	input wire logic [7:0] invDom,
	input wire logic [26:0] invKey
);
	logic [`IDAR_ENTRIES-1:0] valid_reg;
	logic [27:0] key_reg [`IDAR_ENTRIES];
	logic [26:0] mask_reg [`IDAR_ENTRIES];
	logic [7:0] dom_reg [`IDAR_ENTRIES];
	logic [35:0] data_reg [`IDAR_ENTRIES];
	logic [1:0] victim_reg;
	logic [`IDAR_ENTRIES-1:0] hitVec;
	logic [`IDAR_ENTRIES-1:0] invVec;

	// per-entry match; bit 27 of the key marks a leaf entry
	for (genvar i = 0; i < `IDAR_ENTRIES; i++) begin : g_match
		assign hitVec[i] = valid_reg[i] && key_reg[i][27] == lookKey[27]
			&& ((key_reg[i][26:0] ^ lookKey[26:0]) & mask_reg[i]) == 27'h0
			&& (!lookKey[27] || dom_reg[i] == lookDom);
		assign invVec[i] = invEn && (invGran == idar_pkg::IDAR_INV_ALL
			|| (invGran == idar_pkg::IDAR_INV_DOM && dom_reg[i] == invDom)
			|| (invGran == idar_pkg::IDAR_INV_PAGE && key_reg[i][27]
			&& ((key_reg[i][26:0] ^ invKey) & mask_reg[i]) == 27'h0));
	end

	// first matching entry wins
	always_comb begin
		lookHit = |hitVec;
		lookData = 36'h0;
		lookMask = `IDAR_MASK_4K;
		for (int j = `IDAR_ENTRIES - 1; j >= 0; j--) begin
			if (hitVec[j]) begin
				lookData = data_reg[j];
				lookMask = mask_reg[j];
			end
		end
	end

	// valid bits and round-robin victim
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			valid_reg <= '0;
			victim_reg <= 2'h0;
		end else if (clkEn) begin
			valid_reg <= (valid_reg & ~invVec) | ({{(`IDAR_ENTRIES-1){1'b0}}, fillEn} << victim_reg);
			if (fillEn) victim_reg <= victim_reg + 2'h1;
		end
	end

	// entry contents, written on fill only
	always_ff @(posedge sys_clk) begin
		if (clkEn && fillEn) begin
			key_reg[victim_reg] <= fillKey;
			mask_reg[victim_reg] <= fillMask;
			dom_reg[victim_reg] <= fillDom;
			data_reg[victim_reg] <= fillData;
		end
	end
endmodule // idar_tlb
`default_nettype wire

/* verification/idar_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// table memory and sink
// ****************
module idar_far_model #(
	parameter logic [26:0] ROOT_PG = 27'h1,
	parameter logic [26:0] CTX_PG = 27'h2,
	parameter logic [26:0] TBL_PG = 27'h3
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic memReqValid,
	input wire logic [38:0] memReqAddr,
	output logic memRspValid,
	output logic [63:0] memRspData,
	input wire logic fwdValid,
	output logic fwdReady,
	output logic fwdComplete,
	input wire logic superFlag,
	input wire logic holeMode,
	output logic [7:0] rdCount
);
	logic pend;
	logic [2:0] waitCnt;
	logic [2:0] doneSh;
	logic [63:0] word;
	wire fire = pend && !memReqValid && waitCnt == 3'h0;
	wire [26:0] pg = memReqAddr[38:12];
	wire isRoot = (pg == ROOT_PG) || (pg == ROOT_PG + 27'h1);
	wire isTbl = pg == TBL_PG;
	wire [26:0] ptr = isRoot ? CTX_PG : ((pg == CTX_PG) || isTbl) ? TBL_PG : 27'h0;
	wire pres = isRoot ? !holeMode : ((pg == CTX_PG) || isTbl);
	// queue words read as zero apart from the domain byte, global scope
	wire [63:0] entry = {8'h05, 17'h0, ptr, 4'h0, superFlag && isTbl, 6'h0, pres};
	// one read at a time, random latency, stale data inverted
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pend <= 1'b0;
			waitCnt <= 3'h0;
			word <= 64'h0;
			rdCount <= 8'h0;
			memRspValid <= 1'b0;
			memRspData <= 64'h0;
			doneSh <= 3'h0;
			fwdReady <= 1'b0;
		end else begin
			fwdReady <= #1 (($urandom % 3) != 0);
			doneSh <= #1 {doneSh[1:0], fwdValid && fwdReady};
			memRspValid <= #1 fire;
			if (fire)
				memRspData <= #1 word;
			else if (memRspValid)
				memRspData <= #1 ~memRspData;
			if (memReqValid) begin
				pend <= 1'b1;
				waitCnt <= 3'($urandom % 4);
				word <= entry;
				rdCount <= rdCount + 8'h1;
			end else if (pend && waitCnt != 3'h0)
				waitCnt <= waitCnt - 3'h1;
			else if (pend)
				pend <= 1'b0;
		end
	end
	assign fwdComplete = doneSh[2];
endmodule // idar_far_model
`default_nettype wire

/* verification/test_io_dma_address_remapper.sv */
`timescale 1ns/1ps
`default_nettype none
module test_io_dma_address_remapper;
	localparam logic [26:0] ROOT = 27'h00100;
	localparam logic [26:0] CTX = 27'h00200;
	localparam logic [26:0] TBL = 27'h4c345;
	logic sys_clk = 0, nrst = 0, reqValid = 0, reqWrite = 0, reqExternal = 0, faultClear = 0;
	logic transEnable = 0, bootProtect = 0, defaultCtxEnable = 0, superFlag = 0, holeMode = 0;
	logic intrRemapEnable = 0;
	logic [15:0] reqBdf = 0, b, gfx = 16'h0010;
	logic [38:0] reqAddr = 0, a, gA, defaultCtxPtr = 0, vb = 39'h00000c0000;
	logic [38:0] bypassBase = 39'h0012300000, bypassLimit = 39'h00123fffff;
	logic [3:0] reqByteEn = 4'hf, fwdByteEn, gBe;
	logic [7:0] qiTail = 0, rdCount, qiHead, n;
	logic reqReady, fwdValid, fwdWrite, fwdUnsupported, fwdFault, fwdReady, fwdComplete, gF, gU;
	logic memReqValid, memRspValid, invDone, faultValid, faultOverflow, faultMsi;
	logic [38:0] fwdAddr, memReqAddr, faultAddr;
	logic [63:0] memRspData;
	logic [15:0] faultBdf;
	int bad_count = 0, n_tests = 0, msiCount = 0, k, i;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (faultMsi === 1'b1) msiCount++;
	idar_remapper dut_u (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1), .reqValid(reqValid),
		.reqBdf(reqBdf), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqByteEn(reqByteEn),
		.reqExternal(reqExternal), .reqReady(reqReady), .fwdValid(fwdValid), .fwdAddr(fwdAddr),
		.fwdWrite(fwdWrite), .fwdByteEn(fwdByteEn), .fwdUnsupported(fwdUnsupported),
		.fwdFault(fwdFault), .fwdReady(fwdReady), .fwdComplete(fwdComplete),
		.memReqValid(memReqValid), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
		.memRspData(memRspData), .transEnable(transEnable), .bootProtect(bootProtect),
		.intrRemapEnable(intrRemapEnable), .defaultCtxEnable(defaultCtxEnable), .gfxBdf(gfx),
		.rootPtrGfx({ROOT + 27'h1, 12'h0}), .rootPtrDef({ROOT, 12'h0}),
		.defaultCtxPtr(defaultCtxPtr), .defaultDomain(8'h05), .bypassBase(bypassBase),
		.bypassLimit(bypassLimit), .videoBiosBase(vb), .intrTableBase({TBL, 12'h0}),
		.qiEnable(1'b1), .qiBase(39'h0000700000), .qiTail(qiTail), .qiHead(qiHead),
		.invDone(invDone),
		.faultValid(faultValid), .faultBdf(faultBdf), .faultAddr(faultAddr),
		.faultOverflow(faultOverflow), .faultMsi(faultMsi), .faultClear(faultClear));
	idar_far_model #(.ROOT_PG(ROOT), .CTX_PG(CTX), .TBL_PG(TBL)) far_u (.sys_clk(sys_clk),
		.nrst(nrst), .memReqValid(memReqValid), .memReqAddr(memReqAddr),
		.memRspValid(memRspValid), .memRspData(memRspData), .fwdValid(fwdValid),
		.fwdReady(fwdReady), .fwdComplete(fwdComplete), .superFlag(superFlag),
		.holeMode(holeMode), .rdCount(rdCount));
	// ****************
	// checks and bus tasks
	// ****************
	task automatic chkV(input string nm, input logic [38:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkB(input string nm, input logic e, g);
		chkV(nm, {38'h0, e}, {38'h0, g});
	endtask
	function automatic logic [38:0] rnd();
		return {1'b1, 6'($urandom), 32'($urandom)};
	endfunction
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic xfer(input logic [15:0] bd, input logic [38:0] ad, input logic w, x);
		for (k = 0; reqReady !== 1'b1 && k < 99; k++) step();
		reqValid = 1;
		reqBdf = bd;
		reqAddr = ad;
		reqWrite = w;
		reqExternal = x;
		reqByteEn = 4'($urandom);
		step();
		reqValid = 0;
		for (k = 0; fwdValid !== 1'b1 && k < 999; k++) step();
		chkB("fwdValid", 1'b1, fwdValid);
		chkB("fwdWrite", w, fwdWrite);
		{gA, gBe, gF, gU} = {fwdAddr, fwdByteEn, fwdFault, fwdUnsupported};
		for (k = 0; fwdValid === 1'b1 && k < 99; k++) step();
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		k = $urandom(32'h2fb0);
		repeat (6) @(posedge sys_clk);
		#1 nrst = 1;
		step();
		transEnable = 1;
		a = {19'h00fee, 20'($urandom)};
		xfer(16'h0200, a, 1'b1, 1'b0);
		chkV("msiAddr", a, gA);
		intrRemapEnable = 1;
		xfer(16'h0200, a, 1'b1, 1'b0);
		chkV("intrAddr", {19'h00fee, TBL[3:0], 4'h0, 12'h000}, gA);
		intrRemapEnable = 0;
		$display("test msi done");
		transEnable = 0;
		bootProtect = 1;
		a = rnd();
		xfer(16'h0300, a, 1'b1, 1'b0);
		chkV("bootAddr", vb, gA);
		chkV("wrMask", 39'h0, {35'h0, gBe});
		chkV("faultAddr", a, faultAddr);
		chkV("faultBdf", 39'h300, {23'h0, faultBdf});
		xfer(16'h0300, rnd(), 1'b0, 1'b1);
		chkB("unsupp", 1'b1, gU);
		chkB("overflow", 1'b1, faultOverflow);
		chkV("faultKept", a, faultAddr);
		chkV("msiPulses", 39'd1, 39'(msiCount));
		faultClear = 1;
		step();
		faultClear = 0;
		chkB("cleared", 1'b0, faultValid);
		$display("test fault done");
		bootProtect = 0;
		transEnable = 1;
		xfer(16'h0300, bypassLimit, 1'b1, 1'b0);
		chkV("bypass", bypassLimit, gA);
		chkV("bypassBe", {35'h0, reqByteEn}, {35'h0, gBe});
		for (i = 0; i < 6; i++) begin
			a = rnd();
			b = (i == 5) ? gfx : {8'(i + 1), 8'h08};
			xfer(b, a, 1'b0, 1'b0);
			chkV("walk4k", {TBL, a[11:0]}, gA);
		end
		n = rdCount;
		xfer(b, a, 1'b0, 1'b0);
		chkV("hitAddr", {TBL, a[11:0]}, gA);
		chkV("hitReads", {31'h0, n}, {31'h0, rdCount});
		$display("test walk done");
		qiTail = 8'h01;
		for (k = 0; invDone !== 1'b1 && k < 999; k++) step();
		chkB("invDone", 1'b1, invDone);
		step();
		chkV("qiHead", 39'h1, {31'h0, qiHead});
		superFlag = 1;
		n = rdCount;
		// first pass repeats the cached graphics access: it must walk again
		for (i = 0; i < 2; i++) begin
			if (i) a = rnd();
			xfer(i ? 16'h0108 : gfx, a, 1'b0, 1'b0);
			chkV("super1g", {TBL[26:18], a[29:0]}, gA);
			if (!i) chkV("invReads", {31'h0, n + 8'h3}, {31'h0, rdCount});
		end
		$display("test superpage done");
		holeMode = 1;
		xfer(16'h4400, rnd(), 1'b0, 1'b0);
		chkV("noTable", vb, gA);
		chkB("faultFlag", 1'b1, gF);
		defaultCtxEnable = 1;
		defaultCtxPtr = {TBL, 12'h0};
		a = rnd();
		xfer(16'h4500, a, 1'b0, 1'b0);
		chkV("defCtx", {TBL[26:18], a[29:0]}, gA);
		// default table two levels deep, then a missing first level
		defaultCtxPtr = {CTX, 12'h0};
		a = {2'h1, 37'(rnd())};
		xfer(16'h4600, a, 1'b0, 1'b0);
		chkV("super2m", {TBL[26:9], a[20:0]}, gA);
		defaultCtxPtr = {27'h7, 12'h0};
		xfer(16'h4700, a ^ 39'h0000200000, 1'b0, 1'b0);
		chkB("walkFault", 1'b1, gF);
		$display("test default context done");
		test_done();
	end
endmodule // test_io_dma_address_remapper
`default_nettype wire
